// ===== testbench/caf_core_model.sv
// behavioural controller core: answers each tx_start with tx_fail or
// tx_done after a delay that the bench sets.
// assumes one clock shared with the block and a synchronous reset.
`timescale 1ns/1ns
module caf_core_model (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic tx_start,
   input wire logic [3:0] fail_cnt,
   input wire logic [15:0] dly,
   output logic tx_done,
   output logic tx_fail
);
   logic busy;
   logic [15:0] cnt;
   logic [3:0] fails;
   // an answer never comes before a start, so the order rule holds here
   always @(posedge clk) begin
      tx_done <= 1'b0;
      tx_fail <= 1'b0;
      if (!reset_n) begin
         busy <= 1'b0;
         fails <= 4'h0;
      end else if (tx_start) begin
         busy <= 1'b1;
         cnt <= dly;
      end else if (busy) begin
         if (cnt != 16'h0) begin
            cnt <= cnt - 16'h1;
         end else begin
            busy <= 1'b0;
            // fail attempts first, then succeed
            if (fails < fail_cnt) begin
               tx_fail <= 1'b1;
               fails <= fails + 4'h1;
            end else begin
               tx_done <= 1'b1;
               fails <= 4'h0;
            end
         end
      end
   end
endmodule

// ===== testbench/tb_top.sv
// bench for the filter / transmit / transceiver control block.
// assumes the register map in caf_regs.svh and a 125 MHz clock.
`timescale 1ns/1ns
`include "caf_regs.svh"
module tb_top;
   logic clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, tx_stamp = 32'h0, time_now, v;
   logic rx_valid = 1'b0, rx_ide = 1'b0, rx_rtr = 1'b0;
   logic [28:0] rx_id = 29'h0;
   logic [7:0] rx_data0 = 8'h00, rx_data1 = 8'h00;
   logic rx_accept, rx_reject, tx_req = 1'b0, tx_ready, tx_start;
   logic tx_done, tx_fail, tx_ok, tx_drop, bus_activity = 1'b0;
   logic xcvr_pin_a, xcvr_pin_b, ctl_sleep, wake_local, wake_remote;
   logic [3:0] fail_cnt = 4'h0;
   logic [15:0] dly = 16'h2;
   logic [31:0] t_start, t_done, t0, late;
   logic [31:0] cur = 32'h0;
   int error_cnt = 0, samples_checked = 0, starts = 0, wl = 0, wrm = 0;
   always #4 clk = ~clk;
   caf_filter_tx_ctrl DUT (.clk(clk), .reset_n(reset_n), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_valid(rx_valid),
      .rx_ide(rx_ide), .rx_rtr(rx_rtr), .rx_id(rx_id),
      .rx_data0(rx_data0), .rx_data1(rx_data1), .rx_accept(rx_accept),
      .rx_reject(rx_reject), .tx_req(tx_req), .tx_stamp(tx_stamp),
      .tx_ready(tx_ready), .tx_start(tx_start), .tx_done(tx_done),
      .tx_fail(tx_fail), .tx_ok(tx_ok), .tx_drop(tx_drop),
      .bus_activity(bus_activity), .xcvr_pin_a(xcvr_pin_a),
      .xcvr_pin_b(xcvr_pin_b), .ctl_sleep(ctl_sleep),
      .wake_local(wake_local), .wake_remote(wake_remote),
      .time_now(time_now));
   caf_core_model core (.clk(clk), .reset_n(reset_n), .tx_start(tx_start),
      .fail_cnt(fail_cnt), .dly(dly), .tx_done(tx_done), .tx_fail(tx_fail));
   // event counters; pulses last one cycle so they are sampled per edge
   always @(posedge clk) begin
      if (wake_local === 1'b1) wl++;
      if (wake_remote === 1'b1) wrm++;
      if (tx_start === 1'b1) begin
         starts++;
         t_start = time_now;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // stop with the old settings first, so nothing changes while running
   task automatic setc(input logic [31:0] c, input logic [31:0] m,
      input logic [31:0] k);
      wreg(`CAF_OFS_CTRL, cur & 32'hFFFFFEFF);
      wreg(`CAF_OFS_CTRL, c);
      wreg(`CAF_OFS_MASK, m);
      wreg(`CAF_OFS_CODE, k);
      wreg(`CAF_OFS_CTRL, c | 32'h00000100);
      cur = c | 32'h00000100;
   endtask
   task automatic frame(input logic ide, input logic rtr,
      input logic [28:0] id, input logic [7:0] d0, input logic [7:0] d1,
      input logic acc);
      @(posedge clk);
      {rx_ide, rx_rtr, rx_id, rx_data0, rx_data1} <= {ide, rtr, id, d0, d1};
      rx_valid <= 1'b1;
      @(posedge clk);
      rx_valid <= 1'b0;
      #1 chk({rx_accept, rx_reject}, {acc, ~acc});
   endtask
   // one request; the wait is bounded so a lost answer cannot hang
   task automatic send(input logic [31:0] stamp, input logic ok);
      int n;
      for (n = 0; n < 3000 && tx_ready !== 1'b1; n++) @(posedge clk);
      @(posedge clk);
      tx_req <= 1'b1;
      tx_stamp <= stamp;
      @(posedge clk);
      tx_req <= 1'b0;
      #1 chk(tx_ready, 1'b0);
      for (n = 0; n < 3000; n++) begin
         @(posedge clk);
         #1 if (tx_ok === 1'b1 || tx_drop === 1'b1) break;
      end
      t_done = time_now;
      chk({tx_ok, tx_drop}, {ok, ~ok});
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      error_cnt++;
      report_and_stop;
   end
   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      rreg(`CAF_OFS_MASK, v); chk(v, 32'h0FFFFFFF);
      rreg(`CAF_OFS_CODE, v); chk(v, 32'h0);
      rreg(`CAF_OFS_CTRL, v); chk(v, 32'h0);
      rreg(`CAF_OFS_XCVR, v); chk(v, 32'h3);
      rreg(8'h40, v); chk(v, 32'h0);
      $display("reset values done");
      // single standard: id, rtr and both data bytes
      setc(32'h0, 32'h0, 32'h0246AA55);
      frame(0, 0, 29'h123, 8'hAA, 8'h55, 1);
      frame(0, 0, 29'h123, 8'hAA, 8'h54, 0);
      frame(0, 1, 29'h123, 8'hAA, 8'h55, 0);
      frame(1, 0, 29'h123, 8'hAA, 8'h55, 0);
      setc(32'h0, 32'h000000FF, 32'h0246AA55);
      frame(0, 0, 29'h123, 8'hAA, 8'h54, 1);
      // single extended: 29 id bits and rtr
      setc(32'h1, 32'h0, 32'h3579BDE2);
      frame(1, 0, 29'h1ABCDEF1, 8'h00, 8'h00, 1);
      frame(1, 0, 29'h1ABCDEF0, 8'h00, 8'h00, 0);
      frame(0, 0, 29'h0DEF1, 8'h00, 8'h00, 0);
      // dual standard: filter one adds a data byte, filter two has none
      setc(32'h2, 32'h0, 32'h246AA8AC);
      frame(0, 0, 29'h123, 8'hAA, 8'h00, 1);
      frame(0, 0, 29'h123, 8'hAB, 8'h00, 0);
      frame(0, 0, 29'h456, 8'h3C, 8'h00, 1);
      frame(0, 0, 29'h457, 8'hAA, 8'h00, 0);
      // dual extended: upper 16 id bits only, either filter
      setc(32'h3, 32'h0, 32'hABCD1234);
      frame(1, 0, {16'hABCD, 13'h1FFF}, 8'h00, 8'h00, 1);
      frame(1, 1, {16'h1234, 13'h0}, 8'h00, 8'h00, 1);
      frame(1, 0, {16'h1235, 13'h0}, 8'h00, 8'h00, 0);
      frame(0, 0, 29'h123, 8'h00, 8'h00, 0);
      // a fully open mask passes any frame of the right format
      setc(32'h3, 32'hFFFFFFFF, 32'hABCD1234);
      frame(1, 0, {16'h1235, 13'h0}, 8'h00, 8'h00, 1);
      $display("filter modes done");
      // retry after a failure, then no retry
      setc(32'h0, 32'h0FFFFFFF, 32'h0);
      fail_cnt <= 4'h1;
      starts = 0;
      send(32'h0, 1); chk(starts, 2);
      setc(32'h4, 32'h0FFFFFFF, 32'h0);
      starts = 0;
      send(32'h0, 0); chk(starts, 1);
      fail_cnt <= 4'h0;
      // a late frame with catch-up on: the next keeps its slot
      setc(32'h18, 32'h0FFFFFFF, 32'h0);
      dly <= 16'd500;
      t0 = time_now;
      send(t0 + 2, 1);
      late = t_done - t0 - 2;
      chk(late >= 3, 1);
      dly <= 16'h2;
      send(t0 + 8, 1); chk(t_start <= t0 + 9, 1);
      // catch-up ignored without timestamped mode
      setc(32'h08, 32'h0FFFFFFF, 32'h0);
      send(time_now + 1000, 1);
      // catch-up off: the following frame keeps the gap, timeline slips
      setc(32'h10, 32'h0FFFFFFF, 32'h0);
      dly <= 16'd500;
      t0 = time_now;
      send(t0 + 2, 1);
      late = t_done - t0 - 2;
      dly <= 16'h2;
      send(t0 + 8, 1); chk(t_start + 1 >= t0 + 8 + late, 1);
      // relative time base restarts the shared timer from zero
      setc(32'h20, 32'h0FFFFFFF, 32'h0);
      rreg(`CAF_OFS_TIME, v); chk(v < 32'h2, 1);
      chk(time_now < 32'h2, 1);
      $display("transmit done");
      // internal kind refuses the transceiver word
      wreg(`CAF_OFS_XCVR, 32'h100);
      rreg(`CAF_OFS_XCVR, v); chk(v, 32'h3);
      rreg(`CAF_OFS_STAT, v); chk(v & 32'h1, 32'h1);
      setc(32'hC0, 32'h0FFFFFFF, 32'h0);
      wreg(`CAF_OFS_XCVR, 32'h101);
      rreg(`CAF_OFS_XCVR, v); chk(v, 32'h101);
      chk({xcvr_pin_a, xcvr_pin_b}, 2'b10);
      chk(ctl_sleep, 1);
      wreg(`CAF_OFS_XCVR, 32'h002);
      rreg(`CAF_OFS_XCVR, v);
      chk({xcvr_pin_a, xcvr_pin_b}, 2'b01);
      chk(ctl_sleep, 1'b0);
      chk(wl, 32'h1);
      wreg(`CAF_OFS_XCVR, 32'h100);
      @(posedge clk);
      bus_activity <= 1'b1;
      @(posedge clk);
      bus_activity <= 1'b0;
      rreg(`CAF_OFS_XCVR, v); chk(v, 32'h3);
      chk({ctl_sleep, xcvr_pin_a, xcvr_pin_b}, 3'b011);
      chk(wrm, 32'h1);
      $display("transceiver control done");
      report_and_stop;
   end
endmodule

// ===== verilog/caf_filter_tx_ctrl.sv
// acceptance filter, transmit scheduler and transceiver control.
// assumes a plain register port with read data one cycle later, and
// frame/transmit strobes from a CAN controller core on the same clock.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "caf_regs.svh"

module caf_filter_tx_ctrl (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic rx_valid,
   input wire logic rx_ide,
   input wire logic rx_rtr,
   input wire logic [28:0] rx_id,
   input wire logic [7:0] rx_data0,
   input wire logic [7:0] rx_data1,
   output logic rx_accept,
   output logic rx_reject,
   input wire logic tx_req,
   input wire logic [31:0] tx_stamp,
   output logic tx_ready,
   output logic tx_start,
   input wire logic tx_done,
   input wire logic tx_fail,
   output logic tx_ok,
   output logic tx_drop,
   input wire logic bus_activity,
   output logic xcvr_pin_a,
   output logic xcvr_pin_b,
   output logic ctl_sleep,
   output logic wake_local,
   output logic wake_remote,
   output logic [31:0] time_now
);
   caf_pkg::caf_state_t q, d;

   // every output is a field of the registered state
   assign rdata = q.rdata;
   assign rx_accept = q.rx_acc;
   assign rx_reject = q.rx_rej;
   assign tx_ready = q.tx_ready;
   assign tx_start = q.tx_start;
   assign tx_ok = q.tx_ok;
   assign tx_drop = q.tx_drop;
   assign xcvr_pin_a = q.pin_a;
   assign xcvr_pin_b = q.pin_b;
   assign ctl_sleep = q.sleep;
   assign wake_local = q.wake_l;
   assign wake_remote = q.wake_r;
   assign time_now = q.timer;

   // next-state logic: bus, filter, scheduler, sleep control
   always_comb begin
      logic [31:0] v1, v2, c1, c2;
      logic m1, m2, fmt_ok, dual, go;
      logic [31:0] late;
      v1 = '0;
      v2 = '0;
      c1 = '0;
      c2 = '0;
      fmt_ok = 1'b0;
      dual = 1'b0;
      m1 = 1'b0;
      m2 = 1'b0;
      go = 1'b0;
      late = q.timer - q.due;
      d = q;
      d.rdata = '0;
      d.rx_acc = 1'b0;
      d.rx_rej = 1'b0;
      d.tx_start = 1'b0;
      d.tx_ok = 1'b0;
      d.tx_drop = 1'b0;
      d.wake_l = 1'b0;
      d.wake_r = 1'b0;

      // one microsecond timer tick; run-start with relative base, or base change, zeroes it
      if (q.div == 7'(`CAF_TICK_CYC - 1)) begin
         d.div = '0;
         d.timer = q.timer + 32'h00000001;
      end else begin
         d.div = q.div + 7'h01;
      end

      // register writes; settings are live, host stops traffic first
      if (wr) begin
         unique case (addr)
            `CAF_OFS_CTRL: begin
               d.mode = caf_pkg::caf_fmode_t'(wdata[`CAF_CT_FMODE]);
               d.no_retry = wdata[`CAF_CT_NORETRY];
               d.catchup = wdata[`CAF_CT_CATCHUP];
               d.tx_sched = wdata[`CAF_CT_TXSCHED];
               d.tbase = wdata[`CAF_CT_TBASE];
               d.kind = wdata[`CAF_CT_KIND];
               d.run = wdata[`CAF_CT_RUN];
               // shared timer restarts, so the sibling port sees it too
               if (wdata[`CAF_CT_TBASE] != q.tbase) begin
                  d.timer = '0;
                  d.div = '0;
               end
               // relative base counts from zero at task start
               if (wdata[`CAF_CT_RUN] && !q.run &&
                   wdata[`CAF_CT_TBASE]) begin
                  d.timer = '0;
                  d.div = '0;
               end
               if (wdata[`CAF_CT_CATCHUP]) begin
                  d.slip = '0;
               end
            end
            `CAF_OFS_MASK: d.mask = wdata;
            `CAF_OFS_CODE: d.code = wdata;
            `CAF_OFS_XCVR: begin
               if (q.kind == `CAF_KIND_EXT) begin
                  d.pin_a = wdata[`CAF_XW_PIN_A];
                  d.pin_b = wdata[`CAF_XW_PIN_B];
                  d.sleep = wdata[`CAF_XW_SLEEP];
                  d.wake_l = q.sleep && !wdata[`CAF_XW_SLEEP];
               end else begin
                  d.rej = 1'b1;
               end
            end
            `CAF_OFS_STAT: d.rej = 1'b0;
            default: ;
         endcase
      end

      // remote wakeup overrides whatever sleep pattern was set
      if (q.sleep && bus_activity) begin
         d.pin_a = 1'b1;
         d.pin_b = 1'b1;
         d.sleep = 1'b0;
         d.wake_r = 1'b1;
         d.wake_l = 1'b0;
      end

      // read data stands only in the cycle after the strobe
      if (rd) begin
         unique case (addr)
            `CAF_OFS_CTRL: begin
               d.rdata[`CAF_CT_FMODE] = q.mode;
               d.rdata[`CAF_CT_NORETRY] = q.no_retry;
               d.rdata[`CAF_CT_CATCHUP] = q.catchup;
               d.rdata[`CAF_CT_TXSCHED] = q.tx_sched;
               d.rdata[`CAF_CT_TBASE] = q.tbase;
               d.rdata[`CAF_CT_KIND] = q.kind;
               d.rdata[`CAF_CT_RUN] = q.run;
            end
            `CAF_OFS_MASK: d.rdata = q.mask;
            `CAF_OFS_CODE: d.rdata = q.code;
            `CAF_OFS_XCVR: begin
               d.rdata[`CAF_XW_PIN_A] = q.pin_a;
               d.rdata[`CAF_XW_PIN_B] = q.pin_b;
               d.rdata[`CAF_XW_SLEEP] = q.sleep;
            end
            `CAF_OFS_STAT: begin
               d.rdata[`CAF_ST_REJ] = q.rej;
               d.rdata[`CAF_ST_ASLEEP] = q.sleep;
               d.rdata[`CAF_ST_TXIDLE] = q.tx_ready;
            end
            `CAF_OFS_TIME: d.rdata = q.timer;
            default: ;
         endcase
      end

      // map the frame onto the mask/code layout of the active mode
      unique case (q.mode)
         caf_pkg::CAF_SS: begin
            fmt_ok = !rx_ide;
            v1[27:0] = {rx_id[10:0], rx_rtr, rx_data0, rx_data1};
            c1 = 32'h0FFFFFFF;
         end
         caf_pkg::CAF_SE: begin
            fmt_ok = rx_ide;
            v1[29:0] = {rx_id, rx_rtr};
            c1 = 32'h3FFFFFFF;
         end
         caf_pkg::CAF_DS: begin
            fmt_ok = !rx_ide;
            dual = 1'b1;
            v1[31:12] = {rx_id[10:0], rx_rtr, rx_data0};
            c1 = 32'hFFFFF000;
            v2[11:0] = {rx_id[10:0], rx_rtr};
            c2 = 32'h00000FFF;
         end
         caf_pkg::CAF_DE: begin
            fmt_ok = rx_ide;
            dual = 1'b1;
            v1[31:16] = rx_id[28:13];
            c1 = 32'hFFFF0000;
            v2[15:0] = rx_id[28:13];
            c2 = 32'h0000FFFF;
         end
      endcase
      // a set mask bit drops that bit out of the compare
      m1 = ~|((v1 ^ q.code) & ~q.mask & c1);
      m2 = dual && ~|((v2 ^ q.code) & ~q.mask & c2);

      // one verdict serves the interface and every receive object
      if (rx_valid && q.run && !q.sleep) begin
         d.rx_acc = fmt_ok && (m1 || m2);
         d.rx_rej = !(fmt_ok && (m1 || m2));
      end

      // transmit scheduler; sleep defers pending frames
      go = q.run && !q.sleep &&
           (!q.tx_sched || !late[31]);
      unique case (q.st)
         caf_pkg::TX_IDLE: begin
            if (tx_req) begin
               d.due = tx_stamp + q.slip;
               d.st = caf_pkg::TX_WAIT;
            end
         end
         caf_pkg::TX_WAIT: begin
            if (go) begin
               d.tx_start = 1'b1;
               d.st = caf_pkg::TX_BUSY;
            end
         end
         caf_pkg::TX_BUSY: begin
            if (tx_done) begin
               d.tx_ok = 1'b1;
               d.st = caf_pkg::TX_IDLE;
               // without catchup the lateness carries forward
               if (q.tx_sched && !q.catchup && !late[31]) begin
                  d.slip = q.slip + late;
               end
               if (q.catchup) begin
                  d.slip = '0;
               end
            end else if (tx_fail) begin
               if (q.no_retry) begin
                  d.tx_drop = 1'b1;
                  d.st = caf_pkg::TX_IDLE;
               end else begin
                  d.tx_start = 1'b1;
               end
            end
         end
         default: d.st = caf_pkg::TX_IDLE;
      endcase
      d.tx_ready = (d.st == caf_pkg::TX_IDLE);
   end

   // state register with synchronous reset
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q <= '0;
         q.mode <= caf_pkg::CAF_SS;
         q.kind <= `CAF_KIND_RST;
         q.mask <= `CAF_MASK_RST;
         q.code <= `CAF_CODE_RST;
         q.pin_a <= 1'((`CAF_XW_RST >> `CAF_XW_PIN_A) & 32'h1);
         q.pin_b <= 1'((`CAF_XW_RST >> `CAF_XW_PIN_B) & 32'h1);
         q.sleep <= 1'b0;
         q.st <= caf_pkg::TX_IDLE;
         q.tx_ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   mask_reset_a: assert property (@(posedge clk)
      $rose(reset_n) |-> q.mask == `CAF_MASK_RST && q.code == '0 &&
      q.pin_a && q.pin_b && !q.sleep)
      else $error("reset values wrong");
   verdict_excl_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      rx_valid && q.run && !q.sleep |=> rx_accept != rx_reject)
      else $error("filter verdict missing or double");
   std_only_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      rx_valid && q.run && !q.sleep && rx_ide &&
      (q.mode == caf_pkg::CAF_SS || q.mode == caf_pkg::CAF_DS)
      |=> rx_reject)
      else $error("extended frame passed standard filter");
   ext_only_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      rx_valid && q.run && !q.sleep && !rx_ide &&
      q.mode == caf_pkg::CAF_SE |=> rx_reject)
      else $error("standard frame passed extended filter");
   dual_ext_fmt_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      rx_valid && q.run && !q.sleep && !rx_ide &&
      q.mode == caf_pkg::CAF_DE |=> rx_reject)
      else $error("standard frame passed dual extended filter");
   open_mask_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      rx_valid && q.run && !q.sleep && q.mask == 32'hFFFFFFFF &&
      (rx_ide == (q.mode == caf_pkg::CAF_SE ||
      q.mode == caf_pkg::CAF_DE)) |=> rx_accept)
      else $error("open mask rejected a frame");
   no_retry_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      q.st == caf_pkg::TX_BUSY && !tx_done && tx_fail && q.no_retry
      |=> tx_drop && !tx_start ##1 !tx_start)
      else $error("failed frame retried in no-retry mode");
   retry_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      q.st == caf_pkg::TX_BUSY && !tx_done && tx_fail && !q.no_retry
      |=> tx_start && !tx_drop)
      else $error("failed frame not retried");
   // the lateness of a finished frame never carries over with catchup
   catchup_zero_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      q.st == caf_pkg::TX_BUSY && tx_done && q.catchup |=> q.slip == '0)
      else $error("catchup left a slip behind");
   free_start_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      q.st == caf_pkg::TX_WAIT && q.run && !q.sleep && !q.tx_sched
      |=> tx_start)
      else $error("untimed frame was held back");
   remote_wake_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      ctl_sleep && bus_activity |=> !ctl_sleep && xcvr_pin_a &&
      xcvr_pin_b && wake_remote)
      else $error("remote wakeup did not restore word");
   pin_a_drive_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      wr && addr == `CAF_OFS_XCVR && q.kind == `CAF_KIND_EXT &&
      !(ctl_sleep && bus_activity) && wdata[`CAF_XW_PIN_A] |=> xcvr_pin_a)
      else $error("pin a not driven high");
   pin_a_clear_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      wr && addr == `CAF_OFS_XCVR && q.kind == `CAF_KIND_EXT &&
      !(ctl_sleep && bus_activity) && !wdata[`CAF_XW_PIN_A] |=> !xcvr_pin_a)
      else $error("pin a not driven low");
   pin_b_drive_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      wr && addr == `CAF_OFS_XCVR && q.kind == `CAF_KIND_EXT &&
      !(ctl_sleep && bus_activity) && wdata[`CAF_XW_PIN_B] |=> xcvr_pin_b)
      else $error("pin b not driven high");
   pin_b_clear_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      wr && addr == `CAF_OFS_XCVR && q.kind == `CAF_KIND_EXT &&
      !(ctl_sleep && bus_activity) && !wdata[`CAF_XW_PIN_B] |=> !xcvr_pin_b)
      else $error("pin b not driven low");
   kind_reject_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      wr && addr == `CAF_OFS_XCVR && q.kind != `CAF_KIND_EXT &&
      !(ctl_sleep && bus_activity)
      |=> $stable(xcvr_pin_a) && $stable(xcvr_pin_b) && q.rej)
      else $error("control word taken for internal kind");
   local_wake_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      wr && addr == `CAF_OFS_XCVR && q.kind == `CAF_KIND_EXT &&
      ctl_sleep && !wdata[`CAF_XW_SLEEP] && !bus_activity
      |=> wake_local && !ctl_sleep)
      else $error("local wakeup missing");
   rel_start_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      wr && addr == `CAF_OFS_CTRL && wdata[`CAF_CT_RUN] && !q.run &&
      wdata[`CAF_CT_TBASE] |=> time_now == '0)
      else $error("relative time base did not start at zero");
   base_clear_a: assert property (@(posedge clk)
      disable iff (!reset_n)
      wr && addr == `CAF_OFS_CTRL && wdata[`CAF_CT_TBASE] != q.tbase
      |=> time_now == '0)
      else $error("timer not cleared on base change");
endmodule

// ===== verilog/caf_pkg.sv
// types shared by the acceptance filter / transmit control block.
// assumes nothing beyond the SystemVerilog type system.
package caf_pkg;
   typedef enum logic [1:0] {
      CAF_SS, CAF_SE, CAF_DS, CAF_DE
   } caf_fmode_t;
   typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_BUSY} caf_tx_t;
   typedef struct packed {
      caf_fmode_t mode;
      logic no_retry;
      logic catchup;
      logic tx_sched;
      logic tbase;
      logic [1:0] kind;
      logic run;
      logic [31:0] mask;
      logic [31:0] code;
      logic pin_a;
      logic pin_b;
      logic sleep;
      logic rej;
      logic [6:0] div;
      logic [31:0] timer;
      logic [31:0] slip;
      logic [31:0] due;
      caf_tx_t st;
      logic tx_ready;
      logic [31:0] rdata;
      logic rx_acc;
      logic rx_rej;
      logic tx_start;
      logic tx_ok;
      logic tx_drop;
      logic wake_l;
      logic wake_r;
   } caf_state_t;
endpackage

// ===== verilog/caf_regs.svh
// register offsets, field positions, reset values and timing counts
// of the acceptance filter / transmit / transceiver control block.
// assumes byte addresses on an 8-bit register port, 32-bit words.
`ifndef CAF_REGS_SVH
`define CAF_REGS_SVH
`define CAF_OFS_CTRL 8'h00
`define CAF_OFS_MASK 8'h04
`define CAF_OFS_CODE 8'h08
`define CAF_OFS_XCVR 8'h0C
`define CAF_OFS_STAT 8'h10
`define CAF_OFS_TIME 8'h14
// control word fields
`define CAF_CT_FMODE 1:0
`define CAF_CT_NORETRY 2
`define CAF_CT_CATCHUP 3
`define CAF_CT_TXSCHED 4
`define CAF_CT_TBASE 5
`define CAF_CT_KIND 7:6
`define CAF_CT_RUN 8
// transceiver control word fields
`define CAF_XW_PIN_A 0
`define CAF_XW_PIN_B 1
`define CAF_XW_SLEEP 8
// status word fields
`define CAF_ST_REJ 0
`define CAF_ST_ASLEEP 1
`define CAF_ST_TXIDLE 2
// reset values and encodings
`define CAF_MASK_RST 32'h0FFFFFFF
`define CAF_CODE_RST 32'h00000000
`define CAF_XW_RST 32'h00000003
`define CAF_KIND_EXT 2'h3
`define CAF_KIND_RST 2'h0
// timer tick: 1000 ns per count at an 8 ns clock
`define CAF_TICK_NS 1000
`define CAF_CLK_NS 8
`define CAF_TICK_CYC (`CAF_TICK_NS / `CAF_CLK_NS)
`endif
